/* pkg/sfc_params.svh */
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH

// register offsets, byte addresses
`define SFC_KEY_BASE      12'h000
`define SFC_KEY_LAST      12'h3fc
`define SFC_CMD_OFF       12'h400
`define SFC_TF_OFF        12'h404
`define SFC_STAT_OFF      12'h408

// key sector words
`define SFC_W_ACTION      3'h0
`define SFC_W_FUNC        3'h1
`define SFC_W_FEAT        3'h2
`define SFC_W_STATE       3'h3
`define SFC_W_OPT         3'h4
`define SFC_FETCH_LAST    3'h5

`define SFC_ACT_FEATCTL   16'h0004
`define SFC_FN_SET        16'h0001
`define SFC_FN_GET        16'h0002
`define SFC_FN_FLAGS      16'h0003
`define SFC_FEAT_WCACHE   16'h0001
`define SFC_WC_DEFER      16'h0001
`define SFC_WC_FORCE_ON   16'h0002
`define SFC_WC_FORCE_OFF  16'h0003
`define SFC_OPT_NV_BIT    0

// task-file answers
`define SFC_ERR_OK        8'h00
`define SFC_ERR_ABORT     8'h04
`define SFC_STS_OK        8'h50
`define SFC_STS_ERR       8'h51
`define SFC_TF_RSVD       8'h00

// status register fields
`define SFC_STAT_BUSY     16
`define SFC_STAT_WC       17
`define SFC_STAT_NV       18

`define SFC_SF_EN_RST     1'b1

`endif

/* pkg/sfc_pkg.sv */
package sfc_pkg;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH,
		ST_EXEC
	} sfc_state_t;

	typedef struct packed {
		logic [7:0] err;
		logic [7:0] cnt;
		logic [7:0] num;
		logic [7:0] cyl_lo;
		logic [7:0] cyl_hi;
		logic [7:0] dev_head;
		logic [7:0] status;
	} sfc_tf_t;

	typedef struct packed {
		logic        valid;
		logic        enable;
	} sfc_setf_t;

endpackage

/* logic/sfc_key_mem.sv */
`timescale 1ns/10ps
// 256-word key sector store, registered read
module sfc_key_mem (
	input  wire logic        clk,
	input  wire logic        we,
	input  wire logic [7:0]  waddr,
	input  wire logic [15:0] wdata,
	input  wire logic [7:0]  raddr,
	output logic      [15:0] rdata_q
);
	logic [15:0] mem [0:255];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_q <= mem[raddr];
	end
endmodule

/* logic/sfc_wc_ctl.sv */
`timescale 1ns/10ps
`include "sfc_params.svh"
// write-cache operating state from feature state and set-features
module sfc_wc_ctl (
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic              hard_rst,
	input  wire logic [15:0]       feat_state,
	input  wire sfc_pkg::sfc_setf_t setf,
	output logic                   sf_en_q,
	output logic                   setf_done_q,
	output logic                   wc_active_q
);
	import sfc_pkg::*;

	wire defer     = (feat_state == `SFC_WC_DEFER);
	wire force_on  = (feat_state == `SFC_WC_FORCE_ON);
	wire sf_en_d   = setf.valid ? setf.enable : sf_en_q;
	wire wc_d      = defer ? sf_en_q : force_on;

	always_ff @(posedge clk) begin
		if (srst || hard_rst) begin
			sf_en_q     <= `SFC_SF_EN_RST;
			setf_done_q <= 1'b0;
			wc_active_q <= 1'b0;
		end else begin
			sf_en_q     <= sf_en_d;
			// accepted and completed in every state, never an error
			setf_done_q <= setf.valid;
			wc_active_q <= wc_d;
		end
	end
endmodule

/* logic/sfc_feature_control.sv */
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/10ps
`include "sfc_params.svh"
module sfc_feature_control (
	input  wire logic               clk,
	input  wire logic               srst,
	input  wire logic               hard_rst,
	input  wire logic [11:0]        addr,
	input  wire logic [31:0]        wdata,
	input  wire logic               wr_en,
	input  wire logic               rd_en,
	output logic      [31:0]        rd_data,
	input  wire sfc_pkg::sfc_setf_t setf,
	output logic                    setf_done,
	output logic                    busy,
	output logic                    cmd_done,
	output sfc_pkg::sfc_tf_t        tf,
	output logic                    wc_active,
	output logic                    id_w85_b5
);
	import sfc_pkg::*;

	sfc_state_t  state_q;
	sfc_state_t  state_d;
	logic [2:0]  fetch_q;
	logic [15:0] key_q [0:4];
	logic [15:0] mem_rdata;
	logic [15:0] vol_state_q;
	logic [15:0] nv_state_q;
	logic        vol_is_nv_q;
	logic        done_q;
	sfc_tf_t     tf_q;
	logic [31:0] rd_data_q;
	logic        sf_en;
	logic        wc_q;
	logic        busy_q;

	// register decode
	wire key_sel   = (addr <= `SFC_KEY_LAST) && (addr[1:0] == 2'b00);
	wire cmd_sel   = (addr == `SFC_CMD_OFF);
	wire tf_sel    = (addr == `SFC_TF_OFF);
	wire stat_sel  = (addr == `SFC_STAT_OFF);
	wire idle      = (state_q == ST_IDLE);
	wire key_wr    = wr_en && key_sel && idle;
	wire cmd_start = wr_en && cmd_sel && idle;

	wire [31:0] tf_word   = {tf_q.status, tf_q.num, tf_q.cnt, tf_q.err};
	wire [31:0] stat_word = {13'h0000, vol_is_nv_q, wc_q, !idle, vol_state_q};
	wire [31:0] rd_mux;
	assign rd_mux = tf_sel   ? tf_word   :
	                stat_sel ? stat_word :
	                32'h0000_0000;

	// key sector read address while fetching
	wire [7:0] mem_raddr = {5'h00, fetch_q};

	sfc_key_mem u_key_mem (
		.clk     (clk),
		.we      (key_wr),
		.waddr   (addr[9:2]),
		.wdata   (wdata[15:0]),
		.raddr   (mem_raddr),
		.rdata_q (mem_rdata)
	);

	// command decode
	function automatic logic is_wc_state(input logic [15:0] s);
		return (s == `SFC_WC_DEFER) || (s == `SFC_WC_FORCE_ON) ||
		       (s == `SFC_WC_FORCE_OFF);
	endfunction

	wire act_ok   = (key_q[`SFC_W_ACTION] == `SFC_ACT_FEATCTL);
	wire feat_ok  = (key_q[`SFC_W_FEAT] == `SFC_FEAT_WCACHE);
	wire fn_set   = (key_q[`SFC_W_FUNC] == `SFC_FN_SET);
	wire fn_get   = (key_q[`SFC_W_FUNC] == `SFC_FN_GET);
	wire fn_flags = (key_q[`SFC_W_FUNC] == `SFC_FN_FLAGS);
	wire st_ok    = is_wc_state(key_q[`SFC_W_STATE]);
	wire opt_nv   = key_q[`SFC_W_OPT][`SFC_OPT_NV_BIT];
	wire cmd_ok   = act_ok && feat_ok &&
	                ((fn_set && st_ok) || fn_get || fn_flags);
	wire do_set   = cmd_ok && fn_set;
	wire do_nv    = do_set && opt_nv;
	wire exec     = (state_q == ST_EXEC);

	wire [15:0] flags_word = {15'h0000, vol_is_nv_q};
	wire [15:0] ret_word   = fn_get ? vol_state_q : flags_word;
	wire        ret_valid  = cmd_ok && (fn_get || fn_flags);

	sfc_tf_t tf_d;
	always_comb begin
		tf_d          = '0;
		tf_d.cyl_lo   = `SFC_TF_RSVD;
		tf_d.cyl_hi   = `SFC_TF_RSVD;
		tf_d.dev_head = `SFC_TF_RSVD;
		if (cmd_ok) begin
			tf_d.err    = `SFC_ERR_OK;
			tf_d.status = `SFC_STS_OK;
			tf_d.cnt    = ret_valid ? ret_word[7:0] : `SFC_TF_RSVD;
			tf_d.num    = ret_valid ? ret_word[15:8] : `SFC_TF_RSVD;
		end else begin
			tf_d.err    = `SFC_ERR_ABORT;
			tf_d.status = `SFC_STS_ERR;
			tf_d.cnt    = `SFC_TF_RSVD;
			tf_d.num    = `SFC_TF_RSVD;
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (cmd_start) begin
					state_d = ST_FETCH;
				end
			end
			ST_FETCH: begin
				if (fetch_q == `SFC_FETCH_LAST) begin
					state_d = ST_EXEC;
				end
			end
			ST_EXEC: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= ST_IDLE;
			fetch_q <= 3'h0;
			busy_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			fetch_q <= (state_q == ST_FETCH) ? fetch_q + 3'h1 : 3'h0;
			busy_q  <= (state_d != ST_IDLE);
		end
	end

	// capture words 0..4; read data lags the address by one
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_key
			always_ff @(posedge clk) begin
				if (srst) begin
					key_q[gi] <= 16'h0000;
				end else if (state_q == ST_FETCH && fetch_q == 3'(gi + 1)) begin
					key_q[gi] <= mem_rdata;
				end
			end
		end
	endgenerate

	// stored and live feature state
	always_ff @(posedge clk) begin
		if (srst) begin
			nv_state_q  <= `SFC_WC_DEFER;
			vol_state_q <= `SFC_WC_DEFER;
			vol_is_nv_q <= 1'b1;
		end else if (exec && do_set) begin
			vol_state_q <= key_q[`SFC_W_STATE];
			vol_is_nv_q <= opt_nv;
			if (do_nv) begin
				nv_state_q <= key_q[`SFC_W_STATE];
			end
		end else if (hard_rst) begin
			vol_state_q <= nv_state_q;
			vol_is_nv_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			tf_q   <= '0;
			done_q <= 1'b0;
		end else begin
			done_q <= exec;
			if (exec) begin
				tf_q <= tf_d;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rd_data_q <= 32'h0000_0000;
		end else begin
			rd_data_q <= rd_en ? rd_mux : 32'h0000_0000;
		end
	end

	sfc_wc_ctl u_wc_ctl (
		.clk         (clk),
		.srst        (srst),
		.hard_rst    (hard_rst),
		.feat_state  (vol_state_q),
		.setf        (setf),
		.sf_en_q     (sf_en),
		.setf_done_q (setf_done),
		.wc_active_q (wc_q)
	);

	assign rd_data   = rd_data_q;
	assign cmd_done  = done_q;
	assign busy      = busy_q;
	assign tf        = tf_q;
	assign wc_active = wc_q;
	assign id_w85_b5 = wc_q;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_start;
		idle && wr_en && cmd_sel;
	endsequence

	sequence s_finish;
		cmd_done && !busy;
	endsequence

	a_cmd_latency: assert property (s_start |-> ##8 s_finish)
		else $error("command did not complete in eight cycles");

	a_bad_action: assert property (exec && !act_ok |=>
		tf.err == `SFC_ERR_ABORT && tf.status == `SFC_STS_ERR)
		else $error("wrong action code not aborted");

	a_ok_status: assert property (exec && cmd_ok |=>
		tf.err == `SFC_ERR_OK && tf.status == `SFC_STS_OK && tf.dev_head == 8'h00)
		else $error("success status wrong");

	a_get_bytes: assert property (exec && cmd_ok && fn_get |=>
		{tf.num, tf.cnt} == $past(vol_state_q))
		else $error("feature state bytes wrong");

	a_bad_feature: assert property (exec && act_ok && !feat_ok |=>
		tf.status == `SFC_STS_ERR)
		else $error("unknown feature not aborted");

	a_nv_store: assert property (exec && do_nv |=>
		nv_state_q == $past(key_q[`SFC_W_STATE]))
		else $error("non-volatile state not stored");

	a_vol_revert: assert property (hard_rst && !exec |=>
		vol_state_q == $past(nv_state_q))
		else $error("hard reset did not revert state");

	a_force_on: assert property (vol_state_q == `SFC_WC_FORCE_ON &&
		!hard_rst ##1 vol_state_q == `SFC_WC_FORCE_ON && !hard_rst |-> wc_active)
		else $error("forced cache not enabled");

	a_defer_follow: assert property (vol_state_q == `SFC_WC_DEFER && !srst &&
		!hard_rst ##1 vol_state_q == `SFC_WC_DEFER && !hard_rst |-> wc_active == $past(sf_en))
		else $error("deferred cache not following set-features");

	a_setf_done: assert property (setf.valid && !hard_rst |=> setf_done)
		else $error("set-features not completed");

	a_id_mirror: assert property (id_w85_b5 == wc_active)
		else $error("identify bit differs from cache state");

	sequence s_hold_off;
		vol_state_q == `SFC_WC_FORCE_OFF && !hard_rst;
	endsequence

	a_force_off: assert property (s_hold_off ##1 s_hold_off |-> !wc_active)
		else $error("forced cache not disabled");

	a_flags_bytes: assert property (exec && cmd_ok && fn_flags |=>
		{tf.num, tf.cnt} == {15'h0000, $past(vol_is_nv_q)})
		else $error("option flag bytes wrong");

	a_set_rsvd: assert property (exec && do_set |=>
		tf.num == `SFC_TF_RSVD && tf.cnt == `SFC_TF_RSVD)
		else $error("set returned data bytes");

	a_vol_set: assert property (exec && do_set |=>
		vol_state_q == $past(key_q[`SFC_W_STATE]))
		else $error("new feature state not applied");

	a_nv_keep: assert property (exec && do_set && !opt_nv |=>
		nv_state_q == $past(nv_state_q))
		else $error("volatile set changed stored state");

	a_bad_func: assert property (exec && act_ok && feat_ok &&
		!(fn_set || fn_get || fn_flags) |=> tf.err == `SFC_ERR_ABORT)
		else $error("unknown operation not aborted");

	a_rsvd_regs: assert property (cmd_done |->
		tf.cyl_lo == `SFC_TF_RSVD && tf.cyl_hi == `SFC_TF_RSVD)
		else $error("reserved outputs not zero");

	a_busy_span: assert property (s_start |=> busy [*7] ##1 !busy)
		else $error("command busy time wrong");
endmodule

/* verification/sfc_host_model.sv */
`timescale 1ns/10ps
// host side: key sector, command start, set-features
module sfc_host_model (
	input  wire logic         clk,
	input  wire logic         cmd_done,
	input  wire logic [31:0]  rd_data,
	output logic      [11:0]  addr,
	output logic      [31:0]  wdata,
	output logic              wr_en,
	output logic              rd_en,
	output sfc_pkg::sfc_setf_t setf
);
	import sfc_pkg::*;
	initial begin
		addr = 12'h000;
		wdata = 32'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		setf = '0;
	end
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		wdata <= ~d;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 d = rd_data;
	endtask
	// key words 0..4, then start; done expected within a few cycles
	task automatic cmd(input int a, f, ft, s, o, output logic ok);
		wr(12'h000, 32'(a));
		wr(12'h004, 32'(f));
		wr(12'h008, 32'(ft));
		wr(12'h00c, 32'(s));
		wr(12'h010, 32'(o));
		wr(12'h400, 32'h0);
		ok = 1'b0;
		for (int n = 0; n < 12 && !ok; n++) begin
			@(posedge clk);
			#1 ok = cmd_done;
		end
	endtask
	task automatic sf(input logic en);
		@(posedge clk);
		setf <= '{1'b1, en};
		@(posedge clk);
		setf <= '{1'b0, ~en};
	endtask
endmodule

/* verification/sfc_feature_control_tb_top.sv */
`timescale 1ns/10ps
module sfc_feature_control_tb_top;
	import sfc_pkg::*;
	typedef struct {int act, fn, feat, st, opt, ab, cnt, wc;} sfc_row_t;
	logic        clk, srst, hard_rst, wr_en, rd_en, ok;
	logic        cmd_done, setf_done, busy, wc_active, id_w85_b5;
	logic [11:0] addr;
	logic [31:0] wdata, rd_data, d;
	sfc_setf_t   setf;
	sfc_tf_t     tf;
	int          bad_count, checked, cyc;
	sfc_row_t    rows [14];

	sfc_feature_control dut (.clk(clk), .srst(srst), .hard_rst(hard_rst), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .setf(setf),
		.setf_done(setf_done), .busy(busy), .cmd_done(cmd_done), .tf(tf),
		.wc_active(wc_active), .id_w85_b5(id_w85_b5));
	sfc_host_model host (.clk(clk), .cmd_done(cmd_done), .rd_data(rd_data), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .setf(setf));

	always #5 clk = ~clk;

	task automatic check(input logic [63:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		if (bad_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic run(input sfc_row_t r);
		host.cmd(r.act, r.fn, r.feat, r.st, r.opt, ok);
		check(ok, 1'b1);
		check(tf, {r.ab ? 8'h04 : 8'h00, 8'(r.cnt), 32'h0, r.ab ? 8'h51 : 8'h50});
		@(posedge clk);
		#1 check({wc_active, id_w85_b5}, {2{r.wc[0]}});
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			complete_run();
		end
	end

	initial begin
		clk = 0;
		srst = 1;
		hard_rst = 0;
		cyc = 0;
		rows = '{'{4,2,1,0,0,0,1,1}, '{4,3,1,0,0,0,1,1}, '{4,1,1,3,0,0,0,0},
			'{4,2,1,0,0,0,3,0}, '{4,3,1,0,0,0,0,0}, '{4,1,1,2,1,0,0,1},
			'{4,3,1,0,0,0,1,1}, '{4,2,1,0,0,0,2,1}, '{4,1,1,1,1,0,0,1},
			'{5,2,1,0,0,1,0,1}, '{4,4,1,0,0,1,0,1}, '{4,2,2,0,0,1,0,1},
			'{4,1,1,4,0,1,0,1}, '{4,2,1,0,0,0,1,1}};
		repeat (6) @(posedge clk);
		srst <= 0;
		#1 check({busy, wc_active, tf}, 58'h0);
		repeat (3) @(posedge clk);
		#1 check(wc_active, 1'b1);
		foreach (rows[i]) run(rows[i]);
		// deferring: set-features decides
		// cache state follows one edge after setf_done
		host.sf(1'b0);
		#1 check(setf_done, 1'b1);
		@(posedge clk);
		#1 check(wc_active, 1'b0);
		host.sf(1'b1);
		#1 check(setf_done, 1'b1);
		@(posedge clk);
		#1 check(wc_active, 1'b1);
		// forced off: set-features completes without effect
		run('{4,1,1,3,0,0,0,0});
		host.sf(1'b1);
		#1 check(setf_done, 1'b1);
		@(posedge clk);
		#1 check({wc_active, id_w85_b5}, 2'b00);
		@(posedge clk);
		hard_rst <= 1;
		@(posedge clk);
		hard_rst <= 0;
		run('{4,2,1,0,0,0,1,1});
		host.rd(12'h404, d);
		check(d, 32'h50000100);
		host.rd(12'h40c, d);
		check(d, 32'h0);
		host.rd(12'h408, d);
		check(d, 32'h0006_0001);
		// power-on reset mid-run drops the stored state
		run('{4,1,1,2,1,0,0,1});
		@(posedge clk);
		srst <= 1;
		@(posedge clk);
		#1 check({busy, wc_active, tf}, 58'h0);
		@(posedge clk);
		srst <= 0;
		run('{4,2,1,0,0,0,1,1});
		complete_run();
	end
endmodule
